// ==== lmb_bridge.sv ====
/*
 * Local-bus master bridge: a host access to the window is turned into
 * an arbitrated 8/16-bit demultiplexed local-bus cycle.
 * Assumes host request held until done pulse; inputs synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Each valid window access launches one local-bus master transaction.
// - Request bus, wait for grant, acknowledge grant before driving cycles.
// - Drive address, size flag and page select once bus is owned.
// - Direction signal reflects read or write of current cycle.
// - Data strobe asserts after address, size, select, direction valid.
// - Drive data on writes; sample external data on reads.
// - Cycle ends on acknowledge low or wait timer expiry, first wins.
// - 8-bit mode: single byte maps to address bits, size 1, upper lane.
// - 16-bit mode: even bytes upper, odd lower; halfwords size 0.
// - Unsupported byte enables give access error, no local cycle.
// - Option disables byte swapping on 16-bit transfers.
// - Pages of 8 kByte: 0 first select, 1 second, 2 both, 3 invalid.
// - Master works only with master enable and window enable set.
module lmb_bridge (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        host_req,
	input  wire logic        host_write,
	input  wire logic [14:0] host_addr,
	input  wire logic [3:0]  host_be_n,
	input  wire logic [31:0] host_wdata,
	output logic             host_done,
	output logic             host_timeout,
	output logic      [31:0] host_rdata,
	output logic             access_error,
	input  wire logic        local_master_enable,
	input  wire logic        window_base_enable,
	input  wire logic        port_16bit,
	input  wire logic        swap_disable,
	output logic             local_bus_request,
	input  wire logic        local_bus_grant,
	output logic             local_grant_acknowledge,
	output logic [12:0]      local_address_bus,
	output logic             transfer_size_flag,
	output logic             read_write_direction,
	output logic             local_data_strobe,
	input  wire logic        data_transfer_acknowledge_n,
	output logic             page_select_one,
	output logic             page_select_two,
	input  wire logic [15:0] local_data_bus_in,
	output logic      [15:0] local_data_bus_out,
	output logic             local_data_bus_oe
);
	lmb_pkg::lmb_state_t state;
	logic [4:0]  wait_cnt;
	logic        map_ok;
	logic [1:0]  map_a;
	logic        map_size;
	logic [15:0] map_wd;
	logic [1:0]  page;
	logic        page_ok;
	logic        go;
	logic        cyc_end;
	logic        rd_load;
	logic [31:0] rd_word;
	logic        pend;

	// ---------------------------------------------------------------
	// Byte-enable mapping
	// ---------------------------------------------------------------
	always_comb begin
		map_ok   = 1'b1;
		map_a    = 2'h0;
		map_size = 1'b1;
		map_wd   = 16'h0;
		case (host_be_n)
			lmb_pkg::BE_B0: begin
				map_a  = 2'h0;
				map_wd = {host_wdata[7:0], 8'h0};
			end
			lmb_pkg::BE_B1: begin
				map_a  = 2'h1;
				map_wd = port_16bit ? {8'h0, host_wdata[15:8]}
					: {host_wdata[15:8], 8'h0};
			end
			lmb_pkg::BE_B2: begin
				map_a  = 2'h2;
				map_wd = {host_wdata[23:16], 8'h0};
			end
			lmb_pkg::BE_B3: begin
				map_a  = 2'h3;
				map_wd = port_16bit ? {8'h0, host_wdata[31:24]}
					: {host_wdata[31:24], 8'h0};
			end
			lmb_pkg::BE_LO: begin
				map_ok   = port_16bit;
				map_a    = 2'h0;
				map_size = 1'b0;
				map_wd   = swap_disable ? host_wdata[15:0]
					: {host_wdata[7:0], host_wdata[15:8]};
			end
			lmb_pkg::BE_HI: begin
				map_ok   = port_16bit;
				map_a    = 2'h2;
				map_size = 1'b0;
				map_wd   = swap_disable ? host_wdata[31:16]
					: {host_wdata[23:16], host_wdata[31:24]};
			end
			default: map_ok = 1'b0;
		endcase
	end

	assign page    = host_addr[lmb_pkg::PAGE_MSB:lmb_pkg::PAGE_LSB];
	assign page_ok = (page != 2'h3);
	assign pend    = host_req && local_master_enable && window_base_enable;
	assign go      = pend && map_ok && page_ok;
	assign cyc_end = !data_transfer_acknowledge_n || (wait_cnt == 5'h0);

	// ---------------------------------------------------------------
	// Cycle sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= lmb_pkg::ST_IDLE;
		end else begin
			case (state)
				lmb_pkg::ST_IDLE: if (go) state <= lmb_pkg::ST_ARB;
				lmb_pkg::ST_ARB:
					if (local_bus_grant) state <= lmb_pkg::ST_ADDR;
				lmb_pkg::ST_ADDR: state <= lmb_pkg::ST_DATA;
				lmb_pkg::ST_DATA:
					if (cyc_end) state <= lmb_pkg::ST_END;
				lmb_pkg::ST_END: state <= lmb_pkg::ST_IDLE;
				default: state <= lmb_pkg::ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Wait-state timer
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= lmb_pkg::WAIT_LOAD;
		end else if (state != lmb_pkg::ST_DATA) begin
			wait_cnt <= lmb_pkg::WAIT_LOAD;
		end else if (wait_cnt != 5'h0) begin
			wait_cnt <= wait_cnt - 5'h1;
		end
	end

	// ---------------------------------------------------------------
	// Bus ownership
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			local_bus_request       <= 1'b0;
			local_grant_acknowledge <= 1'b0;
		end else begin
			if (state == lmb_pkg::ST_IDLE && go)
				local_bus_request <= 1'b1;
			else if (state == lmb_pkg::ST_END)
				local_bus_request <= 1'b0;
			if (state == lmb_pkg::ST_ARB && local_bus_grant)
				local_grant_acknowledge <= 1'b1;
			else if (state == lmb_pkg::ST_END)
				local_grant_acknowledge <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Address phase outputs
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			local_address_bus    <= 13'h0;
			transfer_size_flag   <= 1'b1;
			read_write_direction <= 1'b1;
			page_select_one      <= 1'b0;
			page_select_two      <= 1'b0;
			local_data_bus_out   <= 16'h0;
			local_data_bus_oe    <= 1'b0;
		end else if (state == lmb_pkg::ST_ARB && local_bus_grant) begin
			local_address_bus    <= {host_addr[12:2], map_a};
			transfer_size_flag   <= map_size;
			read_write_direction <= !host_write;
			page_select_one      <= (page == lmb_pkg::PAGE_0) ||
				(page == lmb_pkg::PAGE_2);
			page_select_two      <= (page == lmb_pkg::PAGE_1) ||
				(page == lmb_pkg::PAGE_2);
			local_data_bus_out   <= map_wd;
			local_data_bus_oe    <= host_write;
		end else if (state == lmb_pkg::ST_END) begin
			page_select_one      <= 1'b0;
			page_select_two      <= 1'b0;
			local_data_bus_oe    <= 1'b0;
			read_write_direction <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Data strobe
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			local_data_strobe <= 1'b0;
		end else if (state == lmb_pkg::ST_ADDR) begin
			local_data_strobe <= 1'b1;
		end else if (state == lmb_pkg::ST_DATA && cyc_end) begin
			local_data_strobe <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Read data unpacking and status
	// ---------------------------------------------------------------
	always_comb begin
		rd_word = 32'h0;
		case (local_address_bus[1:0])
			2'h0: rd_word[15:0] = !transfer_size_flag ?
				(swap_disable ? local_data_bus_in
				 : {local_data_bus_in[7:0], local_data_bus_in[15:8]})
				: {8'h0, local_data_bus_in[15:8]};
			2'h1: rd_word[15:8] = port_16bit ? local_data_bus_in[7:0]
				: local_data_bus_in[15:8];
			2'h2: rd_word[31:16] = !transfer_size_flag ?
				(swap_disable ? local_data_bus_in
				 : {local_data_bus_in[7:0], local_data_bus_in[15:8]})
				: {8'h0, local_data_bus_in[15:8]};
			2'h3: rd_word[31:24] = port_16bit ? local_data_bus_in[7:0]
				: local_data_bus_in[15:8];
			default: rd_word = 32'h0;
		endcase
	end

	assign rd_load = (state == lmb_pkg::ST_DATA) && cyc_end &&
		read_write_direction;

	lmb_hold_reg u_hold (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.load     (rd_load),
		.din      (rd_word),
		.dout     (host_rdata)
	);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_done    <= 1'b0;
			host_timeout <= 1'b0;
			access_error <= 1'b0;
		end else begin
			host_done    <= (state == lmb_pkg::ST_DATA) && cyc_end;
			host_timeout <= (state == lmb_pkg::ST_DATA) && cyc_end &&
				data_transfer_acknowledge_n;
			access_error <= (state == lmb_pkg::ST_IDLE) && pend &&
				!(map_ok && page_ok) && !access_error;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_NO_CYCLE_WITHOUT_GRANT: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(local_data_strobe) |-> local_grant_acknowledge)
		else $error("strobe without grant acknowledge");
	AST_STROBE_AFTER_ADDR: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(local_data_strobe) |-> $past(page_select_one ||
		page_select_two))
		else $error("strobe before select");
	AST_TIMER_BOUND: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		$rose(local_data_strobe) |-> ##[1:17] !local_data_strobe)
		else $error("cycle not ended by timer");
	AST_ACK_ENDS: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(state == lmb_pkg::ST_DATA && !data_transfer_acknowledge_n)
		|=> !local_data_strobe ##0 host_done)
		else $error("acknowledge did not end cycle");
	AST_PAGE_NOT_BOTH_IDLE: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		local_data_strobe |-> (page_select_one || page_select_two))
		else $error("strobe with no page select");
	AST_ERR_NO_REQ: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		access_error |-> !local_bus_request)
		else $error("error access requested the bus");
	AST_DISABLED_IDLE: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!local_master_enable && state == lmb_pkg::ST_IDLE)
		|=> !local_bus_request)
		else $error("request while master disabled");
	AST_WRITE_DRIVES: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		local_data_strobe |-> (local_data_bus_oe == !read_write_direction))
		else $error("data drive mismatches direction");
	AST_RELEASE: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		host_done |=> !local_bus_request && !page_select_one &&
		!page_select_two)
		else $error("bus not released after cycle");
endmodule
`default_nettype wire

// ==== lmb_pkg.sv ====
/*
 * Package for the local-bus master bridge: timing counts, page codes,
 * byte-enable patterns and state encoding.
 * Assumes a single 25 MHz core clock.
 */
`default_nettype none
package lmb_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 40;
	localparam int WAIT_TIME_NS    = 640;
	localparam int WAIT_CYCLES     = WAIT_TIME_NS / CLK_PERIOD_NS;
	localparam logic [4:0] WAIT_LOAD = 5'(WAIT_CYCLES);

	// ---------------------------------------------------------------
	// Window and page layout
	// ---------------------------------------------------------------
	localparam int PAGE_LSB       = 13;
	localparam int PAGE_MSB       = 14;
	localparam int ADDR_W         = 13;
	localparam logic [1:0] PAGE_0 = 2'h0;
	localparam logic [1:0] PAGE_1 = 2'h1;
	localparam logic [1:0] PAGE_2 = 2'h2;

	// ---------------------------------------------------------------
	// Byte enables (active low)
	// ---------------------------------------------------------------
	localparam logic [3:0] BE_B0  = 4'he;
	localparam logic [3:0] BE_B1  = 4'hd;
	localparam logic [3:0] BE_B2  = 4'hb;
	localparam logic [3:0] BE_B3  = 4'h7;
	localparam logic [3:0] BE_LO  = 4'hc;
	localparam logic [3:0] BE_HI  = 4'h3;

	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARB  = 5'h02,
		ST_ADDR = 5'h04,
		ST_DATA = 5'h08,
		ST_END  = 5'h10
	} lmb_state_t;
endpackage
`default_nettype wire

// ==== lmb_hold_reg.sv ====
/*
 * Holding register for read data returned to the host side.
 * Assumes the core clock and active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module lmb_hold_reg (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        load,
	input  wire logic [31:0] din,
	output logic      [31:0] dout
);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dout <= 32'h0;
		end else if (load) begin
			dout <= din;
		end
	end
endmodule
`default_nettype wire

// ==== lmb_peer.sv ====
/*
 * Local-bus peer model: arbiter that grants after a set wait, and a
 * slave that answers the strobe with acknowledge and read data.
 * Assumes the bridge clock and reset; the waits are set by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module lmb_peer (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        local_bus_request,
	input  wire logic        local_data_strobe,
	input  wire logic        read_write_direction,
	input  wire logic [3:0]  gnt_wait,
	input  wire logic [3:0]  ack_wait,
	input  wire logic        ack_off,
	input  wire logic [15:0] rd_word,
	output logic             local_bus_grant,
	output logic             data_transfer_acknowledge_n,
	output logic      [15:0] local_data_bus_in
);
	logic [3:0] gcnt;
	logic [3:0] acnt;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			gcnt <= 4'h0;
			local_bus_grant <= 1'b0;
		end else if (!local_bus_request) begin
			gcnt <= 4'h0;
			local_bus_grant <= 1'b0;
		end else if (gcnt >= gnt_wait) begin
			local_bus_grant <= 1'b1;
		end else begin
			gcnt <= gcnt + 4'h1;
		end
	end

	// Acknowledge held low until the strobe drops
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acnt <= 4'h0;
			data_transfer_acknowledge_n <= 1'b1;
		end else if (!local_data_strobe) begin
			acnt <= 4'h0;
			data_transfer_acknowledge_n <= 1'b1;
		end else if (ack_off) begin
			data_transfer_acknowledge_n <= 1'b1;
		end else if (acnt >= ack_wait) begin
			data_transfer_acknowledge_n <= 1'b0;
		end else begin
			acnt <= acnt + 4'h1;
		end
	end

	// Read data only under strobe, toggling junk otherwise
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			local_data_bus_in <= 16'h0000;
		end else if (local_data_strobe && read_write_direction) begin
			local_data_bus_in <= rd_word;
		end else begin
			local_data_bus_in <= ~local_data_bus_in;
		end
	end
endmodule
`default_nettype wire

// ==== lmb_bridge_tb.sv ====
/*
 * Self-checking bench for lmb_bridge with the local peer model.
 * Assumes lmb_pkg, lmb_hold_reg, lmb_bridge and lmb_peer compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module lmb_bridge_tb;
	logic        core_clk, rst_n, host_req, host_write, host_done;
	logic        host_timeout, access_error, local_master_enable;
	logic        window_base_enable, port_16bit, swap_disable;
	logic        local_bus_request, local_bus_grant;
	logic        local_grant_acknowledge, transfer_size_flag;
	logic        read_write_direction, local_data_strobe, ack_off;
	logic        data_transfer_acknowledge_n, local_data_bus_oe;
	logic        page_select_one, page_select_two;
	logic [14:0] host_addr;
	logic [3:0]  host_be_n, gnt_wait, ack_wait;
	logic [31:0] host_wdata, host_rdata, s_rd;
	logic [12:0] local_address_bus, s_addr;
	logic [15:0] local_data_bus_in, local_data_bus_out, rd_word, s_data;
	logic [1:0]  s_sel;
	logic        s_seen, s_size, s_dir, s_oe, s_gack;
	logic        e_done, e_to, e_err, req_seen;
	int          cyc;
	int          bad_count = 0;
	int          comparisons = 0;
	localparam logic [3:0]  BE6 [6] = '{4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3};
	localparam logic [1:0]  LA6 [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
	localparam logic        SZ6 [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	localparam logic [15:0] EX6 [6] = '{16'h1100, 16'h0022, 16'h3300,
		16'h0044, 16'h1122, 16'h3344};
	localparam logic [15:0] MK6 [6] = '{16'hff00, 16'h00ff, 16'hff00,
		16'h00ff, 16'hffff, 16'hffff};

	lmb_bridge dut (.core_clk(core_clk), .rst_n(rst_n), .host_req(host_req),
		.host_write(host_write), .host_addr(host_addr),
		.host_be_n(host_be_n), .host_wdata(host_wdata),
		.host_done(host_done), .host_timeout(host_timeout),
		.host_rdata(host_rdata), .access_error(access_error),
		.local_master_enable(local_master_enable),
		.window_base_enable(window_base_enable), .port_16bit(port_16bit),
		.swap_disable(swap_disable), .local_bus_request(local_bus_request),
		.local_bus_grant(local_bus_grant),
		.local_grant_acknowledge(local_grant_acknowledge),
		.local_address_bus(local_address_bus),
		.transfer_size_flag(transfer_size_flag),
		.read_write_direction(read_write_direction),
		.local_data_strobe(local_data_strobe),
		.data_transfer_acknowledge_n(data_transfer_acknowledge_n),
		.page_select_one(page_select_one),
		.page_select_two(page_select_two),
		.local_data_bus_in(local_data_bus_in),
		.local_data_bus_out(local_data_bus_out),
		.local_data_bus_oe(local_data_bus_oe));
	lmb_peer peer (.core_clk(core_clk), .rst_n(rst_n),
		.local_bus_request(local_bus_request),
		.local_data_strobe(local_data_strobe),
		.read_write_direction(read_write_direction), .gnt_wait(gnt_wait),
		.ack_wait(ack_wait), .ack_off(ack_off), .rd_word(rd_word),
		.local_bus_grant(local_bus_grant),
		.data_transfer_acknowledge_n(data_transfer_acknowledge_n),
		.local_data_bus_in(local_data_bus_in));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task close_out;
		$display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One host access; captures the local cycle at strobe rise
	task run(input logic wr, input logic [14:0] a, input logic [3:0] be,
		input logic [31:0] wd);
		{s_seen, req_seen, e_done, e_to, e_err} = 5'h00;
		@(posedge core_clk);
		host_req <= 1'b1;
		host_write <= wr;
		host_addr <= a;
		host_be_n <= be;
		host_wdata <= wd;
		for (cyc = 0; cyc < 80 && !(e_done || e_err); cyc++) begin
			@(posedge core_clk);
			#1;
			req_seen |= local_bus_request;
			if (local_data_strobe && !s_seen) begin
				s_seen = 1'b1;
				s_addr = local_address_bus;
				s_size = transfer_size_flag;
				s_dir = read_write_direction;
				s_sel = {page_select_two, page_select_one};
				s_data = local_data_bus_out;
				s_oe = local_data_bus_oe;
				s_gack = local_grant_acknowledge;
			end
			if (host_done)
				s_rd = host_rdata;
			{e_done, e_to, e_err} = {host_done, host_timeout, access_error};
		end
		@(posedge core_clk);
		host_req <= 1'b0;
		if (!(e_done || e_err)) begin
			chk(32'h0, 32'h1);
			close_out;
		end
		repeat (2) @(posedge core_clk);
		#1;
		chk({local_bus_request, local_grant_acknowledge, local_data_strobe,
			page_select_one, page_select_two, local_data_bus_oe}, 0);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task t_byte8;
		port_16bit <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			gnt_wait <= 4'(3 * i);
			run(1'b1, 15'h0128, ~(4'h1 << i), 32'h44332211);
			chk(s_seen, 1);
			chk(s_gack, 1);
			chk(s_addr, {11'h04a, 2'(i)});
			chk(s_size, 1);
			chk(s_data[15:8], 32'h11 * (i + 1));
			chk({s_dir, s_oe}, 2'b01);
			chk(s_sel, 2'b01);
		end
		gnt_wait <= 4'h0;
	endtask

	task t_lane16;
		port_16bit <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			run(1'b1, 15'h2100, BE6[i], 32'h44332211);
			chk(s_addr[1:0], LA6[i]);
			chk(s_size, SZ6[i]);
			chk(s_data & MK6[i], EX6[i]);
			chk(s_sel, 2'b10);
		end
		swap_disable <= 1'b1;
		run(1'b1, 15'h4000, 4'hc, 32'h44332211);
		chk(s_data, 16'h2211);
		chk(s_sel, 2'b11);
		run(1'b1, 15'h4000, 4'h3, 32'h44332211);
		chk(s_data, 16'h4433);
		swap_disable <= 1'b0;
	endtask

	task t_read;
		port_16bit <= 1'b0;
		rd_word <= 16'hc3a5;
		ack_wait <= 4'h2;
		run(1'b0, 15'h0040, 4'hb, 32'h0);
		chk({s_dir, s_oe, e_to}, 3'b100);
		chk(s_rd[23:16], 8'hc3);
		port_16bit <= 1'b1;
		run(1'b0, 15'h0040, 4'h7, 32'h0);
		chk(s_rd[31:24], 8'ha5);
		run(1'b0, 15'h0040, 4'hc, 32'h0);
		chk(s_rd[15:0], 16'ha5c3);
		swap_disable <= 1'b1;
		run(1'b0, 15'h0040, 4'hc, 32'h0);
		chk(s_rd[15:0], 16'hc3a5);
		swap_disable <= 1'b0;
		ack_wait <= 4'h0;
	endtask

	task t_refuse;
		port_16bit <= 1'b0;
		run(1'b0, 15'h6000, 4'he, 32'h0);
		chk({e_err, req_seen}, 2'b10);
		run(1'b0, 15'h0000, 4'hc, 32'h0);
		chk({e_err, req_seen, s_seen}, 3'b100);
		port_16bit <= 1'b1;
		run(1'b0, 15'h0000, 4'h5, 32'h0);
		chk({e_err, req_seen, s_seen}, 3'b100);
		for (int k = 0; k < 2; k++) begin
			@(posedge core_clk);
			{local_master_enable, window_base_enable} <= k ? 2'b01 : 2'b10;
			host_req <= 1'b1;
			host_be_n <= 4'he;
			{req_seen, e_err} = 2'b00;
			repeat (12) begin
				@(posedge core_clk);
				#1;
				req_seen |= local_bus_request;
				e_err |= access_error;
			end
			chk({req_seen, e_err}, 2'b00);
			@(posedge core_clk);
			host_req <= 1'b0;
			{local_master_enable, window_base_enable} <= 2'b11;
		end
	endtask

	task t_timer;
		ack_off <= 1'b1;
		run(1'b0, 15'h0000, 4'he, 32'h55);
		chk({e_done, e_to}, 2'b11);
		chk(cyc >= lmb_pkg::WAIT_CYCLES && cyc <= lmb_pkg::WAIT_CYCLES + 8, 1);
		ack_off <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// Clock, reset and sequence
	// ---------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		{rst_n, host_req, host_write, port_16bit, swap_disable} = 5'h00;
		{local_master_enable, window_base_enable, ack_off} = 3'b100;
		{host_addr, host_be_n, host_wdata} = {15'h0, 4'hf, 32'h0};
		{gnt_wait, ack_wait, rd_word} = 24'h000000;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		window_base_enable <= 1'b1;
		t_byte8;
		t_lane16;
		t_read;
		t_refuse;
		t_timer;
		close_out;
	end
endmodule
`default_nettype wire
